// [hub_err_pkg.sv]
package hub_err_pkg;
    // ****************************************
    // sizes and register map
    // ****************************************
    localparam int NUM_PORTS = 4;
    localparam int PIN_CNT = 3;
    localparam logic [11:0] OFS_PIN_CTL = 12'h0A4;
    localparam logic [11:0] OFS_PIN_STATE = 12'h0A8;
    localparam logic [11:0] OFS_PIN_LEVELS = 12'h0AC;
    localparam logic [11:0] OFS_UNC = 12'h104;
    localparam logic [11:0] OFS_COR = 12'h110;
    localparam logic [11:0] OFS_SRC_ID = 12'h134;
    localparam logic [11:0] OFS_REMAP_CTL = 12'h184;
    localparam logic [11:0] OFS_XUNC = 12'h208;
    localparam logic [11:0] OFS_HUB_STS = 12'h300;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int MA_BIT = 4;
    localparam int CEIL_BIT = 5;
    localparam int IRQWIN_BIT = 6;
    localparam int UR_BIT = 20;
    localparam int ADV_NF_BIT = 13;
    localparam int MSI_BIT = 8;
    localparam int REMAP_EN_BIT = 0;
    localparam int CEIL_LO = 4;
    localparam int PIN_SW_LO = 8;
    localparam logic [31:0] REMAP_CTL_RST = 32'h0000_00F0;
    localparam logic [31:0] PIN_CTL_RST = 32'h0000_0000;
    localparam int TOP_MEM_BITS = 40;
    localparam int CEIL_BASE_BITS = 36;
    localparam logic [43:0] IRQ_WIN_TAG = 44'h0000_0000_FEE;
    localparam logic [1:0] MODE_EVENT = 2'h1;
    localparam logic [1:0] MODE_SW = 2'h2;

    typedef enum logic [1:0] {
        CPL_OK = 2'h0,
        CPL_UR = 2'h1,
        CPL_DROP = 2'h3
    } cpl_e;

    typedef enum logic [1:0] {
        MSG_COR = 2'h0,
        MSG_NONFATAL = 2'h1,
        MSG_FATAL = 2'h2
    } msg_e;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic valid;
        logic [1:0] port;
        logic write;
        logic translated;
        logic msi;
        logic [9:0] len_dw;
        logic [63:0] addr;
    } inbound_s;

    typedef struct packed {
        logic valid;
        logic [1:0] port;
        msg_e kind;
        logic [15:0] requester_identifier;
    } errmsg_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [1:0] port;
        logic [11:0] addr;
        logic [31:0] wdata;
    } cfg_req_s;

    typedef struct packed {
        logic valid;
        logic [1:0] port;
        cpl_e status;
    } resp_s;

    // true when any address bit at or above position nbits is set
    function automatic logic above_bits(input logic [63:0] addr, input int nbits);
        return (addr >> nbits) != 64'h0;
    endfunction
endpackage

// [inbound_addr_check.sv]
`timescale 1ns/1ps
module inbound_addr_check (
    input wire hub_err_pkg::inbound_s req,
    input wire logic [3:0] host_address_ceiling,
    input wire logic remap_en,
    input wire logic port_wide,
    output logic above_top,
    output logic over_ceiling,
    output logic irq_block,
    output logic msi_bad
);
    // ****************************************
    // address classification
    // ****************************************
    always_comb begin
        above_top = hub_err_pkg::above_bits(req.addr, hub_err_pkg::TOP_MEM_BITS); // RULE1
        over_ceiling = remap_en && req.translated &&
            hub_err_pkg::above_bits(req.addr, hub_err_pkg::CEIL_BASE_BITS + int'(host_address_ceiling)); // RULE4
        irq_block = req.translated && req.write && (req.addr[63:20] == hub_err_pkg::IRQ_WIN_TAG); // RULE5
        msi_bad = req.msi && port_wide && (req.len_dw > 10'h001); // RULE7
    end
endmodule

// [err_pin_drive.sv]
`timescale 1ns/1ps
module err_pin_drive (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [31:0] ctl,
    input wire logic ctl_write,
    input wire logic [2:0] events,
    output logic [2:0] pins,
    output logic [2:0] pin_state
);
    typedef struct packed {
        logic [2:0] pend;
        logic [2:0] pins;
    } pin_state_s;

    pin_state_s r_reg;
    pin_state_s r_next;

    // ****************************************
    // pin drive per assertion mode
    // ****************************************
    always_comb begin
        r_next = r_reg;
        if (ce) begin
            for (int n = 0; n < hub_err_pkg::PIN_CNT; n++) begin
                // set wins over the clear caused by a control write
                r_next.pend[n] = (r_reg.pend[n] && !ctl_write) || events[n];
                if (ctl[2*n +: 2] == hub_err_pkg::MODE_EVENT) begin
                    r_next.pins[n] = r_next.pend[n];
                end else if (ctl[2*n +: 2] == hub_err_pkg::MODE_SW) begin
                    r_next.pins[n] = ctl[hub_err_pkg::PIN_SW_LO + n];
                end else begin
                    r_next.pins[n] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    always_comb begin
        pins = r_reg.pins;
        for (int n = 0; n < hub_err_pkg::PIN_CNT; n++) begin
            pin_state[n] = r_reg.pins[n] && ((ctl[2*n +: 2] == hub_err_pkg::MODE_EVENT) ||
                (ctl[2*n +: 2] == hub_err_pkg::MODE_SW)); // RULE8
        end
    end
endmodule

// [io_hub_error_logging.sv]
`timescale 1ns/1ps
// Contract
// RULE1: any inbound access above 2^40 is master-aborted and sets bit 4 of hub_error_status, remap on or off.
// RULE2: such an abort also sets the unsupported-request bit in the port's uncorrectable status.
// RULE3: with non-fatal severity such an abort signals a normal non-fatal error and leaves bit 13 of correctable status clear.
// RULE4: a translated access above the ceiling in remap control bits 7:4 gets an Unsupported Request completion.
// RULE5: a translated write into the interrupt window at FEExxxxxh is blocked.
// RULE6: internally generated error messages load their requester identifier into error_source_identity.
// RULE7: on a x8 or x16 port an MSI longer than one doubleword sets bit 8 of that port's extra uncorrectable status.
// RULE8: error_pin_state follows the true pin level for every pin in mode 01b or 10b.
// RULE9: error_pin_levels returns the current level of the three error pins in bits 2:0.
// RULE10: ceiling rejects and interrupt-window blocks set their own flags in hub_error_status.
// RULE11: requester identifiers of inbound fatal, non-fatal and correctable messages are captured too.
module io_hub_error_logging (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input wire hub_err_pkg::inbound_s inb,
    input wire hub_err_pkg::errmsg_s emsg,
    input wire hub_err_pkg::cfg_req_s cfg,
    input wire logic [hub_err_pkg::NUM_PORTS-1:0] port_wide,
    input wire logic ur_sev_fatal,
    output hub_err_pkg::resp_s resp,
    output logic [31:0] cfg_rdata,
    output logic cfg_rvalid,
    output logic [2:0] err_sig,
    output logic [2:0] system_error_outputs
);
    localparam int NP = hub_err_pkg::NUM_PORTS;

    typedef struct packed {
        logic [31:0] pin_ctl;
        logic [31:0] remap_ctl;
        logic [31:0] hub_sts;
        logic [NP-1:0][31:0] unc;
        logic [NP-1:0][31:0] cor;
        logic [NP-1:0][31:0] xunc;
        logic [NP-1:0][31:0] sid;
        logic [31:0] rdata;
        logic rvalid;
        hub_err_pkg::resp_s resp;
        logic [2:0] sig;
    } hub_state_s;

    hub_state_s r_reg;
    hub_state_s r_next;
    logic above_top;
    logic over_ceiling;
    logic irq_block;
    logic msi_bad;
    logic [2:0] pin_state;
    logic pin_ctl_write;

    // ****************************************
    // submodules
    // ****************************************
    inbound_addr_check i_inbound_addr_check (
        .req(inb),
        .host_address_ceiling(r_reg.remap_ctl[hub_err_pkg::CEIL_LO +: 4]),
        .remap_en(r_reg.remap_ctl[hub_err_pkg::REMAP_EN_BIT]),
        .port_wide(port_wide[inb.port]),
        .above_top(above_top),
        .over_ceiling(over_ceiling),
        .irq_block(irq_block),
        .msi_bad(msi_bad)
    );

    assign pin_ctl_write = ce && cfg.valid && cfg.write && (cfg.addr == hub_err_pkg::OFS_PIN_CTL);

    // pins assert off the registered severity pulses, one cycle after the pulse and two after the event
    err_pin_drive i_err_pin_drive (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(ce),
        .ctl(r_reg.pin_ctl),
        .ctl_write(pin_ctl_write),
        .events(r_reg.sig),
        .pins(system_error_outputs),
        .pin_state(pin_state)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic [31:0] set_hub;
        logic [31:0] clr_hub;
        logic [NP-1:0][31:0] set_unc;
        logic [NP-1:0][31:0] set_x;
        logic [NP-1:0][31:0] clr_unc;
        logic [NP-1:0][31:0] clr_cor;
        logic [NP-1:0][31:0] clr_x;
        set_hub = '0;
        clr_hub = '0;
        set_unc = '0;
        set_x = '0;
        clr_unc = '0;
        clr_cor = '0;
        clr_x = '0;
        r_next = r_reg;
        if (ce) begin
            r_next.rvalid = 1'b0;
            r_next.resp.valid = 1'b0;
            r_next.sig = 3'h0;
            if (inb.valid) begin
                r_next.resp.valid = 1'b1;
                r_next.resp.port = inb.port;
                r_next.resp.status = hub_err_pkg::CPL_OK;
                if (above_top || over_ceiling) begin
                    r_next.resp.status = hub_err_pkg::CPL_UR; // RULE1 RULE4
                    set_unc[inb.port][hub_err_pkg::UR_BIT] = 1'b1; // RULE2
                    // abort is fatal or non-fatal as ur_sev_fatal selects; advisory bit is never touched
                    r_next.sig[2] = ur_sev_fatal;
                    r_next.sig[1] = !ur_sev_fatal; // RULE3
                    if (above_top) begin
                        set_hub[hub_err_pkg::MA_BIT] = 1'b1; // RULE1
                    end else begin
                        set_hub[hub_err_pkg::CEIL_BIT] = 1'b1; // RULE10
                    end
                end else if (irq_block) begin
                    r_next.resp.status = hub_err_pkg::CPL_DROP; // RULE5
                    set_hub[hub_err_pkg::IRQWIN_BIT] = 1'b1; // RULE10
                end
                if (msi_bad) begin
                    set_x[inb.port][hub_err_pkg::MSI_BIT] = 1'b1; // RULE7
                end
            end
            if (emsg.valid) begin
                // correctable sources in the low half, uncorrectable in the high half
                if (emsg.kind == hub_err_pkg::MSG_COR) begin
                    r_next.sid[emsg.port][15:0] = emsg.requester_identifier; // RULE6 RULE11
                    r_next.sig[0] = 1'b1;
                end else begin
                    r_next.sid[emsg.port][31:16] = emsg.requester_identifier; // RULE6 RULE11
                    r_next.sig[2] = r_next.sig[2] || (emsg.kind == hub_err_pkg::MSG_FATAL);
                    r_next.sig[1] = r_next.sig[1] || (emsg.kind == hub_err_pkg::MSG_NONFATAL);
                end
            end
            if (cfg.valid && cfg.write) begin
                if (cfg.addr == hub_err_pkg::OFS_PIN_CTL) begin
                    r_next.pin_ctl = cfg.wdata;
                end else if (cfg.addr == hub_err_pkg::OFS_REMAP_CTL) begin
                    r_next.remap_ctl = cfg.wdata;
                end else if (cfg.addr == hub_err_pkg::OFS_HUB_STS) begin
                    clr_hub = cfg.wdata;
                end else if (cfg.addr == hub_err_pkg::OFS_UNC) begin
                    clr_unc[cfg.port] = cfg.wdata;
                end else if (cfg.addr == hub_err_pkg::OFS_COR) begin
                    clr_cor[cfg.port] = cfg.wdata;
                end else if (cfg.addr == hub_err_pkg::OFS_XUNC) begin
                    clr_x[cfg.port] = cfg.wdata;
                end
            end
            if (cfg.valid && !cfg.write) begin
                r_next.rvalid = 1'b1;
                if (cfg.addr == hub_err_pkg::OFS_PIN_CTL) begin
                    r_next.rdata = r_reg.pin_ctl;
                end else if (cfg.addr == hub_err_pkg::OFS_PIN_STATE) begin
                    r_next.rdata = {29'h0, pin_state}; // RULE8
                end else if (cfg.addr == hub_err_pkg::OFS_PIN_LEVELS) begin
                    r_next.rdata = {29'h0, system_error_outputs}; // RULE9
                end else if (cfg.addr == hub_err_pkg::OFS_UNC) begin
                    r_next.rdata = r_reg.unc[cfg.port];
                end else if (cfg.addr == hub_err_pkg::OFS_COR) begin
                    r_next.rdata = r_reg.cor[cfg.port];
                end else if (cfg.addr == hub_err_pkg::OFS_SRC_ID) begin
                    r_next.rdata = r_reg.sid[cfg.port];
                end else if (cfg.addr == hub_err_pkg::OFS_REMAP_CTL) begin
                    r_next.rdata = r_reg.remap_ctl;
                end else if (cfg.addr == hub_err_pkg::OFS_XUNC) begin
                    r_next.rdata = r_reg.xunc[cfg.port];
                end else if (cfg.addr == hub_err_pkg::OFS_HUB_STS) begin
                    r_next.rdata = r_reg.hub_sts;
                end else begin
                    r_next.rdata = 32'h0;
                end
            end
            // write-one-to-clear, a new event in the same cycle wins
            r_next.hub_sts = (r_reg.hub_sts & ~clr_hub) | set_hub;
            for (int p = 0; p < NP; p++) begin
                r_next.unc[p] = (r_reg.unc[p] & ~clr_unc[p]) | set_unc[p];
                r_next.cor[p] = r_reg.cor[p] & ~clr_cor[p];
                r_next.xunc[p] = (r_reg.xunc[p] & ~clr_x[p]) | set_x[p];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            r_reg <= '0;
            r_reg.pin_ctl <= hub_err_pkg::PIN_CTL_RST;
            r_reg.remap_ctl <= hub_err_pkg::REMAP_CTL_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    assign resp = r_reg.resp;
    assign cfg_rdata = r_reg.rdata;
    assign cfg_rvalid = r_reg.rvalid;
    assign err_sig = r_reg.sig;

    // ****************************************
    // assertions
    // ****************************************
    property p_top_abort;
        @(posedge clk_sys) disable iff (!rstn)
        ce && inb.valid && inb.addr[63:40] != 24'h0 |=>
            resp.valid && resp.status == hub_err_pkg::CPL_UR && r_reg.hub_sts[4];
    endproperty
    a_top_abort: assert property (p_top_abort) else $error("top abort not flagged"); // RULE1

    property p_top_unc;
        @(posedge clk_sys) disable iff (!rstn)
        ce && inb.valid && above_top |=> r_reg.unc[$past(inb.port)][20];
    endproperty
    a_top_unc: assert property (p_top_unc) else $error("port status missing abort"); // RULE2

    property p_nonfatal;
        @(posedge clk_sys) disable iff (!rstn)
        ce && inb.valid && above_top && !ur_sev_fatal && !(emsg.valid && emsg.kind == hub_err_pkg::MSG_FATAL) |=>
            err_sig[1] && !err_sig[2] && !r_reg.cor[$past(inb.port)][13];
    endproperty
    a_nonfatal: assert property (p_nonfatal) else $error("abort severity wrong"); // RULE3

    property p_ceiling;
        @(posedge clk_sys) disable iff (!rstn)
        ce && inb.valid && !above_top && inb.translated && r_reg.remap_ctl[0] &&
            (inb.addr >> (36 + int'(r_reg.remap_ctl[7:4]))) != 64'h0 |=>
            resp.status == hub_err_pkg::CPL_UR && r_reg.hub_sts[5];
    endproperty
    a_ceiling: assert property (p_ceiling) else $error("ceiling reject missing"); // RULE4

    property p_irq_window;
        @(posedge clk_sys) disable iff (!rstn)
        ce && inb.valid && inb.translated && inb.write && inb.addr[63:20] == 44'h0000_0000_FEE &&
            !above_top && !over_ceiling |=> resp.status == hub_err_pkg::CPL_DROP && r_reg.hub_sts[6];
    endproperty
    a_irq_window: assert property (p_irq_window) else $error("interrupt window write not blocked"); // RULE5

    property p_src_id;
        @(posedge clk_sys) disable iff (!rstn)
        ce && emsg.valid && emsg.kind == hub_err_pkg::MSG_FATAL |=>
            r_reg.sid[$past(emsg.port)][31:16] == $past(emsg.requester_identifier);
    endproperty
    a_src_id: assert property (p_src_id) else $error("source id not captured"); // RULE6

    property p_src_id_cor;
        @(posedge clk_sys) disable iff (!rstn)
        ce && emsg.valid && emsg.kind == hub_err_pkg::MSG_COR |=>
            r_reg.sid[$past(emsg.port)][15:0] == $past(emsg.requester_identifier) && err_sig[0];
    endproperty
    a_src_id_cor: assert property (p_src_id_cor) else $error("correctable source id lost"); // RULE11

    property p_msi;
        @(posedge clk_sys) disable iff (!rstn)
        ce && inb.valid && inb.msi && port_wide[inb.port] && inb.len_dw > 10'h001 |=>
            r_reg.xunc[$past(inb.port)][8];
    endproperty
    a_msi: assert property (p_msi) else $error("long msi not flagged"); // RULE7

    property p_pin_state;
        @(posedge clk_sys) disable iff (!rstn)
        r_reg.pin_ctl[1:0] == 2'h1 || r_reg.pin_ctl[1:0] == 2'h2 |-> pin_state[0] == system_error_outputs[0];
    endproperty
    a_pin_state: assert property (p_pin_state) else $error("pin state differs from pin"); // RULE8

    property p_pin_levels;
        @(posedge clk_sys) disable iff (!rstn)
        ce && cfg.valid && !cfg.write && cfg.addr == 12'h0AC |=>
            cfg_rvalid && cfg_rdata == {29'h0, $past(system_error_outputs)};
    endproperty
    a_pin_levels: assert property (p_pin_levels) else $error("pin levels read wrong"); // RULE9

    property p_inb_answer;
        @(posedge clk_sys) disable iff (!rstn)
        ce && inb.valid |=> resp.valid && resp.port == $past(inb.port);
    endproperty
    a_inb_answer: assert property (p_inb_answer) else $error("no inbound answer"); // RULE1

    property p_state_read;
        @(posedge clk_sys) disable iff (!rstn)
        ce && cfg.valid && !cfg.write && cfg.addr == 12'h0A8 |=> cfg_rvalid && cfg_rdata[2:0] == $past(pin_state);
    endproperty
    a_state_read: assert property (p_state_read) else $error("pin state read wrong"); // RULE8

    property p_pin_sw;
        @(posedge clk_sys) disable iff (!rstn)
        ce && r_reg.pin_ctl[1:0] == 2'h2 |=> system_error_outputs[0] == $past(r_reg.pin_ctl[8]);
    endproperty
    a_pin_sw: assert property (p_pin_sw) else $error("pin not at software level"); // RULE8

    c_top_abort: cover property (@(posedge clk_sys) disable iff (!rstn) ce && inb.valid && above_top);
    c_irq_block: cover property (@(posedge clk_sys) disable iff (!rstn) ce && inb.valid && irq_block);
    c_ceiling: cover property (@(posedge clk_sys) disable iff (!rstn) ce && inb.valid && over_ceiling);
    c_msi_bad: cover property (@(posedge clk_sys) disable iff (!rstn) ce && inb.valid && msi_bad);
    c_pin_event: cover property (@(posedge clk_sys) disable iff (!rstn) r_reg.pin_ctl[5:4] == 2'h1 &&
        system_error_outputs[2]);
endmodule

// [pcie_requester.sv]
`timescale 1ns/1ps
module pcie_requester (
    input wire logic clk_sys,
    input wire hub_err_pkg::resp_s resp,
    input wire logic [2:0] err_sig,
    output hub_err_pkg::inbound_s inb,
    output hub_err_pkg::errmsg_s emsg
);
    hub_err_pkg::resp_s got_resp;
    logic [2:0] got_sig;
    logic got_ok;
    initial begin
        inb = '0;
        emsg = '0;
        got_resp = '0;
        got_sig = '0;
        got_ok = 1'b0;
    end
    // ****************************************
    // one request, then wait for the answer
    // ****************************************
    task automatic issue(input hub_err_pkg::inbound_s r);
        hub_err_pkg::inbound_s idle;
        int n;
        idle = ~r;
        idle.valid = 1'b0;
        @(posedge clk_sys);
        inb <= r;
        @(posedge clk_sys);
        // released lines show junk so a stale address cannot pass as held
        inb <= idle;
        #1;
        n = 0;
        while (!resp.valid && n < 4) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        got_ok = resp.valid;
        got_resp = resp;
        got_sig = err_sig;
    endtask
    task automatic send_msg(input hub_err_pkg::errmsg_s m);
        hub_err_pkg::errmsg_s idle;
        idle = ~m;
        idle.valid = 1'b0;
        @(posedge clk_sys);
        emsg <= m;
        @(posedge clk_sys);
        emsg <= idle;
        #1;
        got_sig = err_sig;
    endtask
endmodule

// [tb_io_hub_error_logging.sv]
`timescale 1ns/1ps
module tb_io_hub_error_logging;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    hub_err_pkg::inbound_s inb;
    hub_err_pkg::errmsg_s emsg;
    hub_err_pkg::cfg_req_s cfg = '0;
    logic [3:0] port_wide = 4'h0;
    logic ur_sev_fatal = 1'b0;
    hub_err_pkg::resp_s resp;
    logic [31:0] cfg_rdata;
    logic cfg_rvalid;
    logic [2:0] err_sig;
    logic [2:0] system_error_outputs;
    int num_errors = 0;
    int total_checks = 0;
    logic [31:0] d;
    always #2.5 clk_sys = ~clk_sys;
    io_hub_error_logging i_io_hub_error_logging (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .inb(inb),
        .emsg(emsg), .cfg(cfg), .port_wide(port_wide), .ur_sev_fatal(ur_sev_fatal), .resp(resp),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .err_sig(err_sig),
        .system_error_outputs(system_error_outputs));
    pcie_requester i_pcie_requester (.clk_sys(clk_sys), .resp(resp), .err_sig(err_sig), .inb(inb),
        .emsg(emsg));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cfg_go(input logic wr, input logic [1:0] port, input logic [11:0] a,
                          input logic [31:0] wd);
        hub_err_pkg::cfg_req_s r;
        hub_err_pkg::cfg_req_s idle;
        r = '{valid: 1'b1, write: wr, port: port, addr: a, wdata: wd};
        idle = ~r;
        idle.valid = 1'b0;
        @(posedge clk_sys);
        cfg <= r;
        @(posedge clk_sys);
        cfg <= idle;
        #1;
    endtask
    task automatic wr(input logic [11:0] a, input logic [1:0] port, input logic [31:0] wd);
        cfg_go(1'b1, port, a, wd);
    endtask
    task automatic rd(input logic [11:0] a, input logic [1:0] port);
        int n;
        cfg_go(1'b0, port, a, 32'h0);
        n = 0;
        while (!cfg_rvalid && n < 4) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (cfg_rvalid !== 1'b1) begin
            num_errors++;
            $display("ERROR %0t no read answer", $time);
            conclude();
        end
        d = cfg_rdata;
    endtask
    task automatic req(input logic [1:0] port, input logic w, input logic tr, input logic msi,
                       input logic [9:0] len, input logic [63:0] a, input hub_err_pkg::cpl_e st);
        i_pcie_requester.issue('{valid: 1'b1, port: port, write: w, translated: tr, msi: msi,
                                 len_dw: len, addr: a});
        if (i_pcie_requester.got_ok !== 1'b1) begin
            num_errors++;
            $display("ERROR %0t no inbound answer", $time);
            conclude();
        end
        check({30'h0, i_pcie_requester.got_resp.status}, {30'h0, st});
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset_values();
        rd(hub_err_pkg::OFS_PIN_CTL, 2'h0);
        check(d, hub_err_pkg::PIN_CTL_RST);
        rd(hub_err_pkg::OFS_REMAP_CTL, 2'h0);
        check(d, hub_err_pkg::REMAP_CTL_RST);
        wr(12'h0F0, 2'h0, 32'hFFFF_FFFF);
        rd(12'h0F0, 2'h0);
        check(d, 32'h0);
    endtask
    task automatic t_above_top();
        req(2'h2, 1'b1, 1'b0, 1'b0, 10'h1, 64'h0000_00FF_FFFF_FFFF, hub_err_pkg::CPL_OK);
        for (int f = 0; f < 2; f++) begin
            ur_sev_fatal <= f[0];
            req(2'h2, 1'b1, 1'b0, 1'b0, 10'h1, 64'h0008_0000_0000_0000, hub_err_pkg::CPL_UR);
            check({29'h0, i_pcie_requester.got_sig}, f ? 32'h4 : 32'h2);
            rd(hub_err_pkg::OFS_HUB_STS, 2'h0);
            check({31'h0, d[hub_err_pkg::MA_BIT]}, 32'h1);
            rd(hub_err_pkg::OFS_UNC, 2'h2);
            check({31'h0, d[hub_err_pkg::UR_BIT]}, 32'h1);
            rd(hub_err_pkg::OFS_COR, 2'h2);
            check({31'h0, d[hub_err_pkg::ADV_NF_BIT]}, 32'h0);
            wr(hub_err_pkg::OFS_HUB_STS, 2'h0, 32'h0000_0010);
            rd(hub_err_pkg::OFS_HUB_STS, 2'h0);
            check({31'h0, d[hub_err_pkg::MA_BIT]}, 32'h0);
            wr(hub_err_pkg::OFS_UNC, 2'h2, 32'h0010_0000);
        end
        ur_sev_fatal <= 1'b0;
    endtask
    task automatic t_ceiling();
        // ceiling field 0 gives the smallest limit, the boundary is then cheap to hit
        wr(hub_err_pkg::OFS_REMAP_CTL, 2'h0, 32'h0000_0001);
        req(2'h0, 1'b0, 1'b1, 1'b0, 10'h1, 64'h0000_000F_FFFF_FFFF, hub_err_pkg::CPL_OK);
        req(2'h0, 1'b0, 1'b0, 1'b0, 10'h1, 64'h0000_0010_0000_0000, hub_err_pkg::CPL_OK);
        req(2'h0, 1'b0, 1'b1, 1'b0, 10'h1, 64'h0000_0010_0000_0000, hub_err_pkg::CPL_UR);
        rd(hub_err_pkg::OFS_HUB_STS, 2'h0);
        check(d & 32'h70, 32'h20);
        ce <= 1'b0;
        wr(hub_err_pkg::OFS_REMAP_CTL, 2'h0, 32'h0000_00F1);
        ce <= 1'b1;
        rd(hub_err_pkg::OFS_REMAP_CTL, 2'h0);
        check(d, 32'h0000_0001);
    endtask
    task automatic t_irq_window();
        req(2'h1, 1'b0, 1'b1, 1'b0, 10'h1, 64'h0000_0000_FEE0_1000, hub_err_pkg::CPL_OK);
        req(2'h1, 1'b1, 1'b0, 1'b0, 10'h1, 64'h0000_0000_FEE0_1000, hub_err_pkg::CPL_OK);
        req(2'h1, 1'b1, 1'b1, 1'b0, 10'h1, 64'h0000_0000_FEEF_FFFC, hub_err_pkg::CPL_DROP);
        rd(hub_err_pkg::OFS_HUB_STS, 2'h0);
        check({31'h0, d[hub_err_pkg::IRQWIN_BIT]}, 32'h1);
    endtask
    task automatic t_msi();
        port_wide <= 4'b0010;
        req(2'h1, 1'b1, 1'b0, 1'b1, 10'h2, 64'h0000_0000_FEE0_0000, hub_err_pkg::CPL_OK);
        req(2'h2, 1'b1, 1'b0, 1'b1, 10'h2, 64'h0000_0000_FEE0_0000, hub_err_pkg::CPL_OK);
        for (int p = 0; p < 3; p++) begin
            rd(hub_err_pkg::OFS_XUNC, p[1:0]);
            check({31'h0, d[hub_err_pkg::MSI_BIT]}, (p == 1) ? 32'h1 : 32'h0);
        end
    endtask
    task automatic t_msgs();
        logic [15:0] ids [3];
        ids = '{16'h1234, 16'h5A5A, 16'hC3C3};
        for (int k = 0; k < 3; k++) begin
            i_pcie_requester.send_msg('{valid: 1'b1, port: 2'h3, kind: hub_err_pkg::msg_e'(k),
                                        requester_identifier: ids[k]});
            check({29'h0, i_pcie_requester.got_sig}, 32'h1 << k);
            rd(hub_err_pkg::OFS_SRC_ID, 2'h3);
            check((k == 0) ? {16'h0, d[15:0]} : {16'h0, d[31:16]}, {16'h0, ids[k]});
        end
    endtask
    task automatic t_pins();
        // pin0 software level high, pin1 latched on non-fatal, pin2 off
        wr(hub_err_pkg::OFS_PIN_CTL, 2'h0, 32'h0000_0106);
        repeat (2) @(posedge clk_sys);
        #1;
        check({29'h0, system_error_outputs}, 32'h1);
        i_pcie_requester.send_msg('{valid: 1'b1, port: 2'h0, kind: hub_err_pkg::MSG_NONFATAL,
                                    requester_identifier: 16'h0001});
        repeat (2) @(posedge clk_sys);
        rd(hub_err_pkg::OFS_PIN_LEVELS, 2'h0);
        check(d, 32'h3);
        rd(hub_err_pkg::OFS_PIN_STATE, 2'h0);
        check(d, 32'h3);
        wr(hub_err_pkg::OFS_PIN_CTL, 2'h0, 32'h0000_0004);
        repeat (2) @(posedge clk_sys);
        rd(hub_err_pkg::OFS_PIN_STATE, 2'h0);
        check(d, 32'h0);
        rd(hub_err_pkg::OFS_PIN_LEVELS, 2'h0);
        check(d, 32'h0);
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset_values();
        t_above_top();
        t_ceiling();
        t_irq_window();
        t_msi();
        t_msgs();
        t_pins();
        conclude();
    end
endmodule
